// File: firing_monitor_pkg.sv
// constants, field layouts and carrier types for the firing status monitor
// assumes a 200 MHz system clock and an spi master on the host side
package firing_monitor_pkg;

	// ====================================================================
	// spi frame
	localparam int            FRAME_BITS     = 16;
	localparam int            CNT_W          = 5;
	localparam logic [4:0]    FRAME_LEN      = 5'h10;
	localparam logic [4:0]    CNT_MAX        = 5'h1F;
	localparam logic [1:0]    MODE_MONITOR   = 2'h3;
	localparam logic [3:0]    MON_SEL_MODE1  = 4'h0;

	// ====================================================================
	// reset values
	localparam logic          REPORT_SEL_RST = 1'h1;
	localparam logic [7:0]    OK_FLAGS_RST   = 8'h00;
	localparam logic [15:0]   LAST_CMD_RST   = 16'h0000;

	// ====================================================================
	// apb register byte offsets
	localparam logic [7:0]    OFS_CTRL       = 8'h00;
	localparam logic [7:0]    OFS_STATE      = 8'h04;
	localparam logic [7:0]    OFS_LAST_CMD   = 8'h08;
	localparam logic [7:0]    OFS_IRQ_STAT   = 8'h0C;
	localparam logic [7:0]    OFS_IRQ_MASK   = 8'h10;

	// ctrl fields
	localparam int            CTRL_PD_DIS    = 0;
	localparam int            CTRL_DIAG_LSB  = 1;
	localparam int            CTRL_DIAG_MSB  = 3;
	localparam int            CTRL_LOOP      = 4;
	localparam logic [2:0]    DIAG_SHORT_BG  = 3'h1;

	// state fields
	localparam int            STATE_OK_LSB   = 0;
	localparam int            STATE_OK_MSB   = 7;
	localparam int            STATE_ACT_LSB  = 8;
	localparam int            STATE_ACT_MSB  = 15;
	localparam int            STATE_SEL      = 16;
	localparam int            STATE_BUSY     = 17;

	// ====================================================================
	// types
	typedef struct packed {
		logic [1:0] mode;
		logic       parity;
		logic [3:0] mon_sel;
		logic       report;
		logic [7:0] chan;
	} monitor_frame_t;

	typedef struct packed {
		logic ok_set;
		logic frame_err;
		logic parity_err;
		logic frame_done;
	} irq_bits_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} spi_pins_t;

	typedef enum logic {
		LINK_IDLE,
		LINK_FRAME
	} link_state_t;

endpackage

// File: pin_sync.sv
// three-flop synchroniser for a group of pins from outside the clock domain
// a new level is accepted once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import firing_monitor_pkg::*;
#(
	parameter int         WIDTH   = 3,
	parameter logic [2:0] RST_VAL = 3'h0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	// ====================================================================
	// state
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.level[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {4{RST_VAL[WIDTH-1:0]}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.level;

endmodule
`default_nettype wire

// File: firing_status_monitor_cmd.sv
// monitor mode 1 command interpreter: spi slave frame decode, response build,
// per-channel firing success flags, report select, apb registers and interrupt
// assumes spi mode 0 (sample on rising sclk, shift on falling), msb first,
// sclk well below a quarter of clk, firing inputs synchronous to clk
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module firing_status_monitor_cmd
	import firing_monitor_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr,
	// spi pins
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                mosi,
	output logic                     miso,
	output logic                     miso_oe,
	// firing logic
	input  wire logic [CHANNELS-1:0] firing_activity_flag,
	input  wire logic [CHANNELS-1:0] firing_ok_set,
	output logic      [CHANNELS-1:0] firing_ok_flag,
	output logic                     firing_report_select,
	// diagnostics
	output logic                     squib_pulldown_sink_off,
	// interrupt
	output logic                     irq
);

	// ====================================================================
	// pin synchronisation
	spi_pins_t pins_raw;
	spi_pins_t pins_lvl;

	assign pins_raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

	pin_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h2)
	) u_pin_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_in    (pins_raw),
		.level_out (pins_lvl)
	);

	// ====================================================================
	// state
	typedef struct packed {
		link_state_t         link;
		logic                sclk_q;
		logic                cs_n_q;
		logic [15:0]         rx_sh;
		logic [15:0]         tx_sh;
		logic [CNT_W-1:0]    bit_cnt;
		logic                report_sel;
		logic [CHANNELS-1:0] ok_flags;
		logic [15:0]         last_cmd;
		logic                pd_dis;
		logic [2:0]          diag_sel;
		logic                loop_test;
		irq_bits_t           irq_stat;
		irq_bits_t           irq_mask;
		logic [31:0]         rdata;
		logic                rerr;
	} mon_state_t;

	mon_state_t st_r;
	mon_state_t st_nxt;

	// ====================================================================
	// edge detection on filtered pins
	logic sclk_rise;
	logic sclk_fall;
	logic cs_start;
	logic cs_end;

	assign sclk_rise = pins_lvl.sclk & ~st_r.sclk_q;
	assign sclk_fall = ~pins_lvl.sclk & st_r.sclk_q;
	assign cs_start  = ~pins_lvl.cs_n & st_r.cs_n_q;
	assign cs_end    = pins_lvl.cs_n & ~st_r.cs_n_q;

	// ====================================================================
	// response frame
	monitor_frame_t resp;
	logic [CHANNELS-1:0] chan_info;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			assign chan_info[g] = st_r.report_sel ? st_r.ok_flags[g]
			                                      : firing_activity_flag[g];
		end
	endgenerate

	always_comb begin
		resp         = '0;
		resp.mode    = MODE_MONITOR;
		resp.mon_sel = MON_SEL_MODE1;
		resp.report  = st_r.report_sel;
		resp.chan    = chan_info;
		resp.parity  = ~(^{resp.mode, resp.mon_sel, resp.report, resp.chan});
	end

	// ====================================================================
	// command decode
	monitor_frame_t cmd;
	logic           len_ok;
	logic           parity_ok;
	logic           mode_ok;
	logic           cmd_good;

	assign cmd       = monitor_frame_t'(st_r.rx_sh);
	assign len_ok    = (st_r.bit_cnt == FRAME_LEN);
	assign parity_ok = ^st_r.rx_sh;
	assign mode_ok   = (cmd.mode == MODE_MONITOR) && (cmd.mon_sel == MON_SEL_MODE1);
	assign cmd_good  = (st_r.link == LINK_FRAME) && cs_end && len_ok && parity_ok && mode_ok;

	// ====================================================================
	// apb decode
	logic apb_setup;
	logic apb_write;
	logic addr_hit;

	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign addr_hit  = (paddr == OFS_CTRL) || (paddr == OFS_STATE) || (paddr == OFS_LAST_CMD)
	                || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);

	// ====================================================================
	// next state
	irq_bits_t           ev;
	irq_bits_t           w1c;
	logic [CHANNELS-1:0] ok_clr;

	always_comb begin
		st_nxt        = st_r;
		ev            = '0;
		w1c           = '0;
		ok_clr        = '0;
		st_nxt.sclk_q = pins_lvl.sclk;
		st_nxt.cs_n_q = pins_lvl.cs_n;

		// link framing
		case (st_r.link)
			LINK_IDLE: begin
				if (cs_start) begin
					st_nxt.link    = LINK_FRAME;
					st_nxt.tx_sh   = resp;
					st_nxt.rx_sh   = '0;
					st_nxt.bit_cnt = '0;
				end
			end
			LINK_FRAME: begin
				if (cs_end) begin
					st_nxt.link = LINK_IDLE;
					if (cmd_good) begin
						st_nxt.report_sel = cmd.report;
						st_nxt.last_cmd   = st_r.rx_sh;
						ok_clr            = cmd.chan;
						ev.frame_done     = 1'b1;
					end else if (len_ok && !parity_ok) begin
						ev.parity_err = 1'b1;
					end else begin
						ev.frame_err = 1'b1;
					end
				end else begin
					if (sclk_rise) begin
						st_nxt.rx_sh = {st_r.rx_sh[14:0], pins_lvl.mosi};
						if (st_r.bit_cnt != CNT_MAX) begin
							st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
						end
					end
					if (sclk_fall && st_r.bit_cnt != '0) begin
						st_nxt.tx_sh = {st_r.tx_sh[14:0], 1'b0};
					end
				end
			end
			default: begin
				st_nxt.link = LINK_IDLE;
			end
		endcase

		// success flags: a set in the clearing cycle survives
		ev.ok_set       = |firing_ok_set;
		st_nxt.ok_flags = (st_r.ok_flags & ~ok_clr) | firing_ok_set;

		// apb writes
		if (apb_write) begin
			case (paddr)
				OFS_CTRL: begin
					st_nxt.pd_dis    = pwdata[CTRL_PD_DIS];
					st_nxt.diag_sel  = pwdata[CTRL_DIAG_MSB:CTRL_DIAG_LSB];
					st_nxt.loop_test = pwdata[CTRL_LOOP];
				end
				OFS_IRQ_STAT: begin
					w1c = irq_bits_t'(pwdata[3:0]);
				end
				OFS_IRQ_MASK: begin
					st_nxt.irq_mask = irq_bits_t'(pwdata[3:0]);
				end
				default: begin
				end
			endcase
		end
		st_nxt.irq_stat = (st_r.irq_stat & ~w1c) | ev;

		// apb read data captured in the setup cycle
		if (apb_setup) begin
			st_nxt.rerr  = ~addr_hit;
			st_nxt.rdata = '0;
			case (paddr)
				OFS_CTRL: begin
					st_nxt.rdata[CTRL_PD_DIS]                 = st_r.pd_dis;
					st_nxt.rdata[CTRL_DIAG_MSB:CTRL_DIAG_LSB] = st_r.diag_sel;
					st_nxt.rdata[CTRL_LOOP]                   = st_r.loop_test;
				end
				OFS_STATE: begin
					st_nxt.rdata[STATE_OK_MSB:STATE_OK_LSB]   = st_r.ok_flags;
					st_nxt.rdata[STATE_ACT_MSB:STATE_ACT_LSB] = firing_activity_flag;
					st_nxt.rdata[STATE_SEL]                   = st_r.report_sel;
					st_nxt.rdata[STATE_BUSY]                  = (st_r.link == LINK_FRAME);
				end
				OFS_LAST_CMD: begin
					st_nxt.rdata[15:0] = st_r.last_cmd;
				end
				OFS_IRQ_STAT: begin
					st_nxt.rdata[3:0] = st_r.irq_stat;
				end
				OFS_IRQ_MASK: begin
					st_nxt.rdata[3:0] = st_r.irq_mask;
				end
				default: begin
				end
			endcase
		end
	end

	// ====================================================================
	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r            <= '0;
			st_r.link       <= LINK_IDLE;
			st_r.cs_n_q     <= 1'b1;
			st_r.report_sel <= REPORT_SEL_RST;
			st_r.ok_flags   <= OK_FLAGS_RST;
			st_r.last_cmd   <= LAST_CMD_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ====================================================================
	// outputs
	assign pready               = psel & penable;
	assign prdata               = st_r.rdata;
	assign pslverr              = psel & penable & st_r.rerr;
	assign miso                 = st_r.tx_sh[15];
	assign miso_oe              = (st_r.link == LINK_FRAME);
	assign firing_ok_flag       = st_r.ok_flags;
	assign firing_report_select = st_r.report_sel;
	assign irq                  = |(st_r.irq_stat & st_r.irq_mask);

	// pulldown disable reaches only the short-to-battery/ground and loop tests
	assign squib_pulldown_sink_off = st_r.pd_dis
	                               & ((st_r.diag_sel == DIAG_SHORT_BG) | st_r.loop_test);

endmodule
`default_nettype wire

// File: firing_monitor_assertions.sv
// port checker for the firing status monitor command interpreter
// assumes it is bound onto the design top module
`timescale 1ns/1ps
`default_nettype none
module firing_monitor_assertions
	import firing_monitor_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	// clock, reset and apb
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	// spi pins and firing signals
	input wire logic                cs_n,
	input wire logic                miso,
	input wire logic                miso_oe,
	input wire logic [CHANNELS-1:0] firing_ok_set,
	input wire logic [CHANNELS-1:0] firing_ok_flag,
	input wire logic                firing_report_select,
	input wire logic                squib_pulldown_sink_off
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ctrl_wr;
	assign ctrl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
	sequence cs_opened; $fell(cs_n); endsequence
	sequence drive_soon; ##[1:8] miso_oe; endsequence
	chk_pd_gate_off: assert property (ctrl_wr && !pwdata[0] |=> !squib_pulldown_sink_off)
		else $error("pulldown off without disable");
	chk_pd_short_on: assert property (ctrl_wr && pwdata[4:0] == 5'h03 |=> squib_pulldown_sink_off)
		else $error("pulldown kept in short test");
	chk_pd_other_diag: assert property (ctrl_wr && pwdata[4:0] == 5'h05 |=> !squib_pulldown_sink_off)
		else $error("pulldown off in other test");
	chk_open_drive: assert property (cs_opened |-> drive_soon)
		else $error("response not driven");
	chk_resp_head: assert property ($rose(miso_oe) |-> miso && !cs_n)
		else $error("response head wrong");
	chk_select_at_end: assert property ($changed(firing_report_select) |-> cs_n)
		else $error("select changed in frame");
	chk_clear_at_end: assert property (|($past(firing_ok_flag) & ~firing_ok_flag) |-> cs_n)
		else $error("flag cleared in frame");
	chk_set_sticky: assert property (|firing_ok_set |=> &(firing_ok_flag | ~$past(firing_ok_set)))
		else $error("flag not set");
endmodule
bind firing_status_monitor_cmd firing_monitor_assertions #(.CHANNELS(CHANNELS)) chk_i (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe), .firing_ok_set(firing_ok_set),
	.firing_ok_flag(firing_ok_flag), .firing_report_select(firing_report_select),
	.squib_pulldown_sink_off(squib_pulldown_sink_off)
);
`default_nettype wire

// File: spi_host_model.sv
// host spi master model sending monitor mode 1 frames
// assumes mode 0, msb first, a 48 ns link clock that stands still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
	import firing_monitor_pkg::*;
(
	// spi pins
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// bad flips the parity; mon sets bits 12 to 9
	task automatic xfer(input logic sel, input logic [7:0] clr, input logic [3:0] mon, input logic bad,
		output logic [15:0] resp);
		monitor_frame_t f;
		f = '{mode: MODE_MONITOR, parity: 1'b0, mon_sel: mon, report: sel, chan: clr};
		f.parity = ~^f ^ bad;
		#1.3 cs_n = 1'b0;
		#48;
		for (int i = 15; i >= 0; i--) begin
			mosi = f[i];
			#24 sclk = 1'b1;
			#24 resp[i] = miso;
			sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		mosi = ~mosi;
		#96;
	endtask
endmodule
`default_nettype wire

// File: firing_status_monitor_cmd_bench.sv
// self-checking bench for the firing status monitor command interpreter
// assumes the host model and the checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module firing_status_monitor_cmd_bench
	import firing_monitor_pkg::*;
;
	logic        clk, pready, pslverr, sclk, cs_n, mosi, miso, miso_oe, sel_o, pd_off, irq;
	logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, act = 8'hA5, ok_set = 8'h00, ok_flag;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] resp;
	logic        err;
	int          num_errors = 0, cmp_count = 0, cyc = 0;

	firing_status_monitor_cmd dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.firing_activity_flag(act), .firing_ok_set(ok_set), .firing_ok_flag(ok_flag),
		.firing_report_select(sel_o), .squib_pulldown_sink_off(pd_off), .irq(irq));
	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			num_errors++;
			results();
		end
	end

	// ====================================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [15:0] mk(input logic sel, input logic [7:0] ch);
		logic [15:0] w;
		w = {2'b11, 1'b0, 4'h0, sel, ch};
		w[13] = ~^w;
		return w;
	endfunction

	// ====================================================================
	// scenarios
	task automatic t_regs();
		logic [19:0] cv = {5'h02, 5'h13, 5'h05, 5'h03};
		logic [3:0]  ex = 4'b0101;
		apb(1'b0, OFS_STATE, 32'h0);
		chk(rd, 32'h0001A500);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFS_CTRL, {27'h0, cv[i*5+:5]});
			chk({31'h0, pd_off}, {31'h0, ex[i]});
		end
	endtask
	task automatic t_report();
		@(posedge clk);
		ok_set <= 8'h3C;
		@(posedge clk);
		ok_set <= 8'h00;
		host.xfer(1'b1, 8'h0C, 4'h0, 1'b0, resp);
		chk({16'h0, resp}, {16'h0, mk(1'b1, 8'h3C)});
		chk({24'h0, ok_flag}, 32'h30);
		host.xfer(1'b0, 8'h00, 4'h0, 1'b0, resp);
		chk({16'h0, resp}, {16'h0, mk(1'b1, 8'h30)});
		chk({31'h0, sel_o}, 32'h0);
		host.xfer(1'b1, 8'h00, 4'h0, 1'b0, resp);
		chk({16'h0, resp}, {16'h0, mk(1'b0, 8'hA5)});
		apb(1'b0, OFS_LAST_CMD, 32'h0);
		chk(rd, {16'h0, mk(1'b1, 8'h00)});
	endtask
	task automatic t_bad();
		host.xfer(1'b0, 8'hFF, 4'h0, 1'b1, resp);
		chk({23'h0, sel_o, ok_flag}, 32'h130);
		host.xfer(1'b0, 8'hFF, 4'h2, 1'b0, resp);
		chk({16'h0, resp}, {16'h0, mk(1'b1, 8'h30)});
		chk({23'h0, sel_o, ok_flag}, 32'h130);
	endtask
	task automatic t_irq();
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk({27'h0, rd[3:0], irq}, 32'h1E);
		apb(1'b1, OFS_IRQ_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_IRQ_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_report();
		t_bad();
		t_irq();
		results();
	end
endmodule
`default_nettype wire
